// ---- hw/fwfp_flash_ctrl.sv ----
`timescale 1ns/1ps
// How it works
// - power field 00 keeps flash always on
// - field 01: standby in idle or stop
// - reset selects always-on power setting
// - start bit cleared: idle entry writes nothing
// - buffer field gives upper ram address bits
// - locked page: no write, immediate interrupt
// - lock bits have no core access path
// - opcode A5 is breakpoint, sets debug flag
// - debug interrupt serviced at highest level
// - breakpoint stalls the core for five cycles
// - after return, one instruction before reentry
// - patch address match returns patch data
// - zero patch address disables substitution
// - patch data register read/write at B9
// - scratch register at E7, no effect
// - page register forms upper flash address
// - 256 pages of 128 bytes, whole page
// - finished page write raises debug interrupt
module fwfp_flash_ctrl
  import fwfp_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // sfr bus from the core
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic [7:0]       sfr_rdata,
  output logic             sfr_hit,
  // core state
  input  wire logic        core_idle,
  input  wire logic        core_stop,
  // instruction fetch path
  input  wire logic        fetch_req,
  input  wire logic [15:0] fetch_addr,
  input  wire logic [7:0]  flash_rdata,
  output logic [7:0]       fetch_data,
  output logic             fetch_valid,
  // executed opcode and interrupt sequencing
  input  wire logic        opcode_exec,
  input  wire logic [7:0]  opcode,
  input  wire logic        reti_exec,
  input  wire logic        instr_done,
  output logic             core_stall,
  output logic             irq_block,
  output logic             debug_irq_set,
  // flash array
  input  wire logic [7:0]  lock_bits,
  output logic             flash_standby,
  output logic             flash_erase,
  output logic             flash_prog,
  output logic [14:0]      flash_addr,
  output logic [7:0]       flash_wdata,
  output logic             flash_busy,
  // ram buffer
  output logic             ram_rd_en,
  output logic [10:0]      ram_addr,
  input  wire logic [7:0]  ram_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  logic [6:0]  ctrl_q;
  logic [7:0]  page_q;
  logic [7:0]  timing_q;
  logic [7:0]  pdata_q;
  logic [7:0]  padr_lo_q;
  logic [7:0]  padr_hi_q;
  logic [7:0]  scratch_q;
  logic [7:0]  rdata_q;
  logic [7:0]  fdata_q;
  logic        fvalid_q;
  logic        idle_d1_q;
  logic        stby_q;
  logic        irq_q;
  logic [2:0]  stall_q;
  logic        step_q;
  logic        seq_busy;
  logic        seq_done;

  // write strobe decode is used once per register, so it is a function
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off);
    wr_hit = sfr_wr && (a == off);
  endfunction

  // protected when the boot page is locked or the page lies in the upper
  // locked area; lock bits only enter here, never the sfr read path
  function automatic logic page_locked(input logic [7:0] pg, input logic [7:0] lk);
    logic [2:0] sz;
    logic [8:0] lim;
    sz  = lk[LOCK_SIZE_LSB +: 3];
    lim = 9'h100 - (9'h100 >> sz);
    page_locked = ((!lk[LOCK_BOOT_BIT]) && (pg == 8'h00)) ||
                  ((sz != LOCK_SIZE_NONE) && ({1'b0, pg} >= lim));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // field views and decode
  wire [1:0]  lp_field   = ctrl_q[CTRL_LP_LSB +: 2];
  wire        wr_start   = ctrl_q[CTRL_WR_BIT];
  wire [3:0]  ram_hi     = ctrl_q[CTRL_RAM_LSB +: 4];
  wire [15:0] patch_adr  = {padr_hi_q, padr_lo_q};
  wire        idle_rise  = core_idle && !idle_d1_q;
  wire        locked     = page_locked(page_q, lock_bits);
  wire        go_write   = idle_rise && wr_start && !locked && !seq_busy;
  wire        refuse     = idle_rise && wr_start && locked && !seq_busy;
  wire        trap_hit   = opcode_exec && (opcode == TRAP_OPCODE);
  wire        patch_on   = (patch_adr != 16'h0000);
  wire        patch_hit  = patch_on && (fetch_addr == patch_adr);
  wire        stby_core  = core_idle || core_stop;
  wire        map_hit    = (sfr_addr == ADDR_WR_CTRL)  || (sfr_addr == ADDR_PAGE_SEL)  ||
                           (sfr_addr == ADDR_PATCH_DAT) || (sfr_addr == ADDR_PATCH_LO) ||
                           (sfr_addr == ADDR_PATCH_HI) || (sfr_addr == ADDR_WR_TIMING) ||
                           (sfr_addr == ADDR_SCRATCH);

  // read mux; reserved bit 7 of the control register reads zero
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (sfr_addr)
      ADDR_WR_CTRL:   rd_mux = {1'b0, ctrl_q};
      ADDR_PAGE_SEL:  rd_mux = page_q;
      ADDR_PATCH_DAT: rd_mux = pdata_q;
      ADDR_PATCH_LO:  rd_mux = padr_lo_q;
      ADDR_PATCH_HI:  rd_mux = padr_hi_q;
      ADDR_WR_TIMING: rd_mux = timing_q;
      ADDR_SCRATCH:   rd_mux = scratch_q;
      default:        rd_mux = 8'h00;
    endcase
  end

  // power decode: a busy write forces standby off from its second cycle; the first keeps the value decoded at idle entry
  logic stby_d;
  always_comb begin
    stby_d = 1'b0;
    unique case (lp_field)
      LP_IDLE_STBY:  stby_d = stby_core;
      LP_FETCH_STBY: stby_d = stby_core || !fetch_req;
      default:       stby_d = 1'b0;
    endcase
    if (seq_busy) stby_d = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // sfr registers; start bit self clears once a write is taken, but a
  // software write in the same cycle wins so a fresh request is kept
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q    <= RST_WR_CTRL[6:0];
      page_q    <= RST_PAGE_SEL;
      timing_q  <= RST_WR_TIMING;
      pdata_q   <= RST_PATCH_DAT;
      padr_lo_q <= RST_PATCH_ADR;
      padr_hi_q <= RST_PATCH_ADR;
      scratch_q <= RST_SCRATCH;
    end else begin
      if (go_write || refuse) ctrl_q[CTRL_WR_BIT] <= 1'b0;
      if (wr_hit(sfr_addr, ADDR_WR_CTRL)) ctrl_q <= sfr_wdata[6:0] & CTRL_WMASK[6:0];
      if (wr_hit(sfr_addr, ADDR_PAGE_SEL)) page_q <= sfr_wdata;
      if (wr_hit(sfr_addr, ADDR_WR_TIMING)) timing_q <= sfr_wdata;
      if (wr_hit(sfr_addr, ADDR_PATCH_DAT)) pdata_q <= sfr_wdata;
      if (wr_hit(sfr_addr, ADDR_PATCH_LO)) padr_lo_q <= sfr_wdata;
      if (wr_hit(sfr_addr, ADDR_PATCH_HI)) padr_hi_q <= sfr_wdata;
      if (wr_hit(sfr_addr, ADDR_SCRATCH)) scratch_q <= sfr_wdata;
    end
  end

  // read data is held until the next read
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) rdata_q <= 8'h00;
    else if (sfr_rd) rdata_q <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch path with single-address substitution, answer one cycle later
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      fdata_q  <= 8'h00;
      fvalid_q <= 1'b0;
    end else begin
      fvalid_q <= fetch_req;
      if (fetch_req) fdata_q <= patch_hit ? pdata_q : flash_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // idle edge, power state and debug interrupt pulse
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      idle_d1_q <= 1'b0;
      stby_q    <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      idle_d1_q <= core_idle;
      stby_q    <= stby_d;
      irq_q     <= trap_hit || refuse || seq_done;
    end
  end

  // breakpoint stall: the core waits so the top-level debug interrupt is
  // taken before the next instruction; priority is set by the core
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) stall_q <= 3'h0;
    else if (trap_hit) stall_q <= TRAP_STALL_CYC;
    else if (stall_q != 3'h0) stall_q <= stall_q - 3'h1;
  end

  // one instruction runs after a return before the interrupt may reenter
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) step_q <= 1'b0;
    else if (reti_exec) step_q <= 1'b1;
    else if (instr_done) step_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // page write sequencer
  fwfp_page_seq u_seq (
    .sys_clk     (sys_clk),
    .nrst        (nrst),
    .start       (go_write),
    .page        (page_q),
    .ram_hi      (ram_hi),
    .timing      (timing_q),
    .ram_rd_en   (ram_rd_en),
    .ram_addr    (ram_addr),
    .ram_rdata   (ram_rdata),
    .flash_erase (flash_erase),
    .flash_prog  (flash_prog),
    .flash_addr  (flash_addr),
    .flash_wdata (flash_wdata),
    .busy        (seq_busy),
    .done        (seq_done)
  );

  // outputs
  assign sfr_rdata     = rdata_q;
  assign sfr_hit       = map_hit;
  assign fetch_data    = fdata_q;
  assign fetch_valid   = fvalid_q;
  assign core_stall    = (stall_q != 3'h0) || trap_hit;
  assign irq_block     = step_q;
  assign debug_irq_set = irq_q;
  assign flash_standby = stby_q;
  assign flash_busy    = seq_busy;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_lp_on;
    (lp_field == LP_ALWAYS_ON) |=> !flash_standby;
  endproperty
  a_lp_on: assert property (p_lp_on) else $error("standby while always on");

  property p_lp_idle;
    (lp_field == LP_IDLE_STBY && core_idle && !seq_busy) |=> flash_standby;
  endproperty
  a_lp_idle: assert property (p_lp_idle) else $error("no standby in idle");

  property p_lp_fetch;
    (lp_field == LP_FETCH_STBY && !fetch_req && !seq_busy) |=> flash_standby;
  endproperty
  a_lp_fetch: assert property (p_lp_fetch) else $error("no standby between fetches");

  property p_start;
    go_write |=> flash_busy ##0 flash_erase;
  endproperty
  a_start: assert property (p_start) else $error("page write did not start");

  property p_no_start;
    (idle_rise && !wr_start && !seq_busy) |=> !flash_busy;
  endproperty
  a_no_start: assert property (p_no_start) else $error("write without start bit");

  property p_ram_hi;
    ram_rd_en |-> (ram_addr[10:7] == ram_hi);
  endproperty
  a_ram_hi: assert property (p_ram_hi) else $error("ram buffer address wrong");

  property p_bit7;
    (sfr_rd && sfr_addr == ADDR_WR_CTRL) |=> (sfr_rdata[7] == 1'b0);
  endproperty
  a_bit7: assert property (p_bit7) else $error("reserved bit read as one");

  property p_locked;
    refuse |=> debug_irq_set && !flash_busy;
  endproperty
  a_locked: assert property (p_locked) else $error("locked page not refused");

  property p_trap;
    trap_hit |-> core_stall ##1 (debug_irq_set && core_stall) ##1 core_stall[*3];
  endproperty
  a_trap: assert property (p_trap) else $error("breakpoint flag or stall wrong");

  property p_step;
    (reti_exec && !instr_done) |=> irq_block;
  endproperty
  a_step: assert property (p_step) else $error("no hold after return");

  property p_patch;
    (fetch_req && patch_hit) |=> (fetch_valid && fetch_data == $past(pdata_q));
  endproperty
  a_patch: assert property (p_patch) else $error("patch data not substituted");

  property p_patch_off;
    (fetch_req && !patch_on) |=> (fetch_data == $past(flash_rdata));
  endproperty
  a_patch_off: assert property (p_patch_off) else $error("substitution while off");

  property p_done;
    seq_done |=> debug_irq_set && !flash_busy;
  endproperty
  a_done: assert property (p_done) else $error("no interrupt after page write");

  property p_lp_rsvd;
    (lp_field == 2'h3) |=> !flash_standby;
  endproperty
  a_lp_rsvd: assert property (p_lp_rsvd) else $error("standby in reserved mode");

  property p_patch_miss;
    (fetch_req && patch_on && fetch_addr != patch_adr) |=>
      (fetch_data == $past(flash_rdata));
  endproperty
  a_patch_miss: assert property (p_patch_miss) else $error("patch on a miss");

  property p_step_end;
    (instr_done && !reti_exec) |=> !irq_block;
  endproperty
  a_step_end: assert property (p_step_end) else $error("hold not released");

  c_page_write: cover property (seq_done);
  c_refuse:     cover property (refuse);
  c_trap:       cover property (trap_hit);
  c_patch:      cover property (fetch_req && patch_hit);

endmodule

// ---- pkg/fwfp_pkg.sv ----
package fwfp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sfr map of the block
  localparam logic [7:0] ADDR_PAGE_SEL  = 8'hAE;
  localparam logic [7:0] ADDR_WR_CTRL   = 8'hAF;
  localparam logic [7:0] ADDR_PATCH_DAT = 8'hB9;
  localparam logic [7:0] ADDR_PATCH_LO  = 8'hBA;
  localparam logic [7:0] ADDR_PATCH_HI  = 8'hBB;
  localparam logic [7:0] ADDR_WR_TIMING = 8'hDD;
  localparam logic [7:0] ADDR_SCRATCH   = 8'hE7;

  ////////////////////////////////////////////////////////////////////////////
  // flash_write_control fields
  localparam int         CTRL_LP_LSB    = 5;
  localparam int         CTRL_WR_BIT    = 4;
  localparam int         CTRL_RAM_LSB   = 0;
  localparam logic [7:0] CTRL_WMASK     = 8'h7F;

  // flash power field encodings (11 is reserved, treated as always active)
  localparam logic [1:0] LP_ALWAYS_ON   = 2'h0;
  localparam logic [1:0] LP_IDLE_STBY   = 2'h1;
  localparam logic [1:0] LP_FETCH_STBY  = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] RST_WR_CTRL    = 8'h00;
  localparam logic [7:0] RST_PAGE_SEL   = 8'h00;
  localparam logic [7:0] RST_WR_TIMING  = 8'h00;
  localparam logic [7:0] RST_PATCH_DAT  = 8'h00;
  localparam logic [7:0] RST_PATCH_ADR  = 8'h00;
  localparam logic [7:0] RST_SCRATCH    = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // lock byte fields (static input, never on the sfr bus)
  localparam int         LOCK_BOOT_BIT  = 4;
  localparam int         LOCK_SIZE_LSB  = 1;
  localparam logic [2:0] LOCK_SIZE_NONE = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // core opcode and cycle counts
  localparam logic [7:0] TRAP_OPCODE    = 8'hA5;
  localparam logic [2:0] TRAP_STALL_CYC = 3'h4;
  localparam logic [6:0] PAGE_LAST_BYTE = 7'h7F;
  localparam int         ERASE_SHIFT    = 4;

  typedef enum logic [2:0] {
    FWFP_SEQ_IDLE,
    FWFP_SEQ_ERASE,
    FWFP_SEQ_READ,
    FWFP_SEQ_PROG,
    FWFP_SEQ_WAIT
  } fwfp_seq_type;

endpackage

// ---- hw/fwfp_page_seq.sv ----
`timescale 1ns/1ps
module fwfp_page_seq
  import fwfp_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  // control from the register side
  input  wire logic        start,
  input  wire logic [7:0]  page,
  input  wire logic [3:0]  ram_hi,
  input  wire logic [7:0]  timing,
  // ram buffer read port, data returns one cycle after the enable
  output logic             ram_rd_en,
  output logic [10:0]      ram_addr,
  input  wire logic [7:0]  ram_rdata,
  // flash array write port
  output logic             flash_erase,
  output logic             flash_prog,
  output logic [14:0]      flash_addr,
  output logic [7:0]       flash_wdata,
  // status
  output logic             busy,
  output logic             done
);

  fwfp_seq_type st_q, st_d;
  logic [6:0]  idx_q;
  logic [15:0] wait_q;
  logic [7:0]  page_q;
  logic [3:0]  ram_hi_q;
  logic [7:0]  wdata_q;
  wire         wait_over = (wait_q == 16'h0000);
  wire         last_byte = (idx_q == PAGE_LAST_BYTE);

  ////////////////////////////////////////////////////////////////////////////
  // erase the whole page, then one read and one program per byte
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      FWFP_SEQ_IDLE:  if (start) st_d = FWFP_SEQ_ERASE;
      FWFP_SEQ_ERASE: if (wait_over) st_d = FWFP_SEQ_READ;
      FWFP_SEQ_READ:  st_d = FWFP_SEQ_PROG;
      FWFP_SEQ_PROG:  st_d = FWFP_SEQ_WAIT;
      FWFP_SEQ_WAIT:  if (wait_over) st_d = last_byte ? FWFP_SEQ_IDLE : FWFP_SEQ_READ;
    endcase
  end

  // page and buffer are latched so a late sfr write cannot tear a page
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st_q     <= FWFP_SEQ_IDLE;
      idx_q    <= 7'h00;
      wait_q   <= 16'h0000;
      page_q   <= 8'h00;
      ram_hi_q <= 4'h0;
      wdata_q  <= 8'h00;
    end else begin
      st_q <= st_d;
      if (st_q == FWFP_SEQ_IDLE && start) begin
        page_q   <= page;
        ram_hi_q <= ram_hi;
        idx_q    <= 7'h00;
        wait_q   <= 16'({timing, 8'h00} >> (8 - ERASE_SHIFT));
      end else if (st_q == FWFP_SEQ_READ) begin
        wdata_q <= ram_rdata;
      end else if (st_q == FWFP_SEQ_PROG) begin
        wait_q <= {8'h00, timing};
      end else if (!wait_over) begin
        wait_q <= wait_q - 16'h0001;
      end
      if (st_q == FWFP_SEQ_WAIT && wait_over) idx_q <= idx_q + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // the ram read is issued the cycle before READ so data lands in READ
  assign ram_rd_en   = (st_d == FWFP_SEQ_READ) && (st_q != FWFP_SEQ_READ);
  assign ram_addr    = {ram_hi_q, (st_q == FWFP_SEQ_WAIT) ? idx_q + 7'h01 : idx_q};
  assign flash_erase = (st_q == FWFP_SEQ_ERASE) && (wait_q == 16'({timing, 8'h00} >> (8 - ERASE_SHIFT)));
  assign flash_prog  = (st_q == FWFP_SEQ_PROG);
  assign flash_addr  = {page_q, idx_q};
  assign flash_wdata = wdata_q;
  assign busy        = (st_q != FWFP_SEQ_IDLE);
  assign done        = (st_q == FWFP_SEQ_WAIT) && wait_over && last_byte;

endmodule

// ---- verif/fwfp_core_model.sv ----
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far side of the block: ram buffer read port and flash array read
module fwfp_core_model
  import fwfp_pkg::*;
(
  // clock
  sys_clk,
  // ram buffer read port
  ram_rd_en,
  ram_addr,
  ram_rdata,
  // flash array read for fetches
  fetch_addr,
  flash_rdata
);
  input  wire logic        sys_clk;
  input  wire logic        ram_rd_en;
  input  wire logic [10:0] ram_addr;
  output logic       [7:0] ram_rdata;
  input  wire logic [15:0] fetch_addr;
  output logic       [7:0] flash_rdata;

  // data answers one cycle after the enable, then flips so stale capture shows
  always @(posedge sys_clk) begin
    if (ram_rd_en) begin
      ram_rdata <= ram_addr[10:3] ^ ram_addr[7:0];
    end else begin
      ram_rdata <= ~ram_rdata;
    end
  end

  // array byte mixes both address bytes so a partial match is visible
  assign flash_rdata = fetch_addr[15:8] ^ fetch_addr[7:0];
endmodule

// ---- verif/flash_write_and_fetch_patch_tb.sv ----
`timescale 1ns/1ps
module flash_write_and_fetch_patch_tb;
  import fwfp_pkg::*;
  // design inputs
  logic        sys_clk, nrst, sfr_wr, sfr_rd, core_idle, core_stop, fetch_req;
  logic        opcode_exec, reti_exec, instr_done;
  logic [7:0]  sfr_addr, sfr_wdata, opcode, lock_bits;
  logic [15:0] fetch_addr;
  // design outputs and model lines
  logic [7:0]  sfr_rdata, fetch_data, flash_rdata, flash_wdata, ram_rdata;
  logic        sfr_hit, fetch_valid, core_stall, irq_block, debug_irq_set;
  logic        flash_standby, flash_erase, flash_prog, flash_busy, ram_rd_en;
  logic [14:0] flash_addr;
  logic [10:0] ram_addr, ra_exp;
  // bench bookkeeping
  int          failures = 0, checked = 0, prog_cnt = 0, irq_cnt = 0;
  logic [7:0]  exp_page;
  logic [3:0]  exp_hi;

  fwfp_flash_ctrl u_dut (.sys_clk, .nrst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sfr_hit, .core_idle, .core_stop, .fetch_req, .fetch_addr,
    .flash_rdata, .fetch_data, .fetch_valid, .opcode_exec, .opcode, .reti_exec,
    .instr_done, .core_stall, .irq_block, .debug_irq_set, .lock_bits,
    .flash_standby, .flash_erase, .flash_prog, .flash_addr, .flash_wdata,
    .flash_busy, .ram_rd_en, .ram_addr, .ram_rdata);
  fwfp_core_model u_core (.sys_clk, .ram_rd_en, .ram_addr, .ram_rdata, .fetch_addr,
    .flash_rdata);

  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // every drive lands 10 ns after an edge, clear of the sampling edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask

  task automatic end_sim();
    if (failures == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // strobes drop and a cycle passes, so back to back calls never re-drive in one step
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
    tick(1);
  endtask

  task automatic sfr_read(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    tick(1);
    sfr_rd = 1'b0;
    chk("sfr_rdata", exp, sfr_rdata);
    tick(1);
  endtask

  task automatic fetch(input logic [15:0] a, input logic [7:0] exp);
    fetch_addr = a;
    fetch_req = 1'b1;
    tick(1);
    fetch_req = 1'b0;
    chk("fetch_valid", 1, fetch_valid);
    chk("fetch_data", exp, fetch_data);
    tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // page write monitor: every programmed byte checked against its ram source
  assign ra_exp = {exp_hi, prog_cnt[6:0]};
  always @(posedge sys_clk) begin
    if (flash_prog) begin
      chk("prog_addr", {exp_page, prog_cnt[6:0]}, flash_addr);
      chk("prog_data", ra_exp[10:3] ^ ra_exp[7:0], flash_wdata);
      prog_cnt++;
    end
    if (debug_irq_set) irq_cnt++;
  end

  task automatic t_regs();
    logic [7:0] ra [8];
    ra = '{ADDR_PAGE_SEL, ADDR_WR_CTRL, ADDR_PATCH_DAT, ADDR_PATCH_LO, ADDR_PATCH_HI,
           ADDR_WR_TIMING, ADDR_SCRATCH, 8'h80};
    chk("standby", 0, flash_standby);
    foreach (ra[i]) sfr_read(ra[i], 8'h00);
    foreach (ra[i]) begin
      sfr_write(ra[i], 8'hFF);
      sfr_read(ra[i], (i == 7) ? 8'h00 : (i == 1) ? 8'h7F : 8'hFF);
      chk("sfr_hit", (i != 7), sfr_hit);
      sfr_write(ra[i], 8'h00);
    end
  endtask

  task automatic t_power();
    for (int lp = 0; lp < 4; lp++) begin
      sfr_write(ADDR_WR_CTRL, 8'(lp << 5));
      tick(3);
      chk("standby_run", (lp == 2), flash_standby);
      // a fetch in flight must keep the array awake; a fetch is driven only in setting 10
      fetch_req = (lp == 2);
      tick(3);
      chk("standby_fetch", 0, flash_standby);
      fetch_req = 1'b0;
      for (int k = 0; k < 2; k++) begin
        core_idle = (k == 0);
        core_stop = (k == 1);
        tick(3);
        chk("standby_sleep", (lp == 1 || lp == 2), flash_standby);
        core_idle = 1'b0;
        core_stop = 1'b0;
        tick(1);
      end
    end
  endtask

  task automatic t_patch();
    sfr_write(ADDR_PATCH_DAT, TRAP_OPCODE);
    fetch(16'h0000, 8'h00);
    sfr_write(ADDR_PATCH_HI, 8'h12);
    sfr_write(ADDR_PATCH_LO, 8'h34);
    fetch(16'h1234, TRAP_OPCODE);
    fetch(16'h1235, 8'h27);
    fetch(16'h0234, 8'h36);
    sfr_write(ADDR_PATCH_HI, 8'h00);
    sfr_write(ADDR_PATCH_LO, 8'h00);
    fetch(16'h0000, 8'h00);
  endtask

  task automatic t_trap();
    opcode = TRAP_OPCODE;
    opcode_exec = 1'b1;
    #5;
    chk("stall", 1, core_stall);
    tick(1);
    opcode_exec = 1'b0;
    chk("irq_set", 1, debug_irq_set);
    for (int i = 0; i < 4; i++) begin
      chk("stall", 1, core_stall);
      tick(1);
    end
    chk("stall", 0, core_stall);
    opcode = 8'h00;
    opcode_exec = 1'b1;
    tick(1);
    opcode_exec = 1'b0;
    chk("irq_set", 0, debug_irq_set);
  endtask

  task automatic t_reti();
    reti_exec = 1'b1;
    tick(1);
    reti_exec = 1'b0;
    chk("irq_block", 1, irq_block);
    tick(2);
    chk("irq_block", 1, irq_block);
    instr_done = 1'b1;
    tick(1);
    instr_done = 1'b0;
    tick(1);
    chk("irq_block", 0, irq_block);
  endtask

  task automatic t_cancel();
    sfr_write(ADDR_WR_CTRL, 8'h13);
    sfr_write(ADDR_WR_CTRL, 8'h03);
    irq_cnt = 0;
    core_idle = 1'b1;
    tick(1);
    chk("busy", 0, flash_busy);
    tick(20);
    chk("irq_count", 0, 16'(irq_cnt));
    core_idle = 1'b0;
    tick(1);
  endtask

  task automatic t_write();
    sfr_write(ADDR_WR_TIMING, 8'h0D);
    sfr_write(ADDR_PAGE_SEL, 8'h05);
    sfr_write(ADDR_WR_CTRL, 8'h13);
    exp_page = 8'h05;
    exp_hi = 4'h3;
    prog_cnt = 0;
    irq_cnt = 0;
    core_idle = 1'b1;
    tick(1);
    chk("busy", 1, flash_busy);
    chk("erase", 1, flash_erase);
    chk("erase_page", 16'h0005, 16'(flash_addr[14:7]));
    for (int i = 0; i < 3000 && irq_cnt == 0; i++) tick(1);
    chk("prog_count", 128, 16'(prog_cnt));
    chk("irq_count", 1, 16'(irq_cnt));
    chk("busy", 0, flash_busy);
    core_idle = 1'b0;
    tick(1);
    sfr_read(ADDR_WR_CTRL, 8'h03);
  endtask

  // locked page: refused at once, nothing programmed
  task automatic t_locked(input logic [7:0] lock, input logic [7:0] page);
    lock_bits = lock;
    sfr_write(ADDR_PAGE_SEL, page);
    sfr_write(ADDR_WR_CTRL, 8'h13);
    prog_cnt = 0;
    core_idle = 1'b1;
    tick(1);
    chk("irq_set", 1, debug_irq_set);
    chk("busy", 0, flash_busy);
    tick(20);
    chk("prog_count", 0, 16'(prog_cnt));
    core_idle = 1'b0;
    tick(1);
    sfr_read(ADDR_WR_CTRL, 8'h03);
    lock_bits = 8'hFF;
  endtask

  task automatic t_rst();
    sfr_write(ADDR_WR_CTRL, 8'h20);
    nrst = 1'b0;
    tick(2);
    nrst = 1'b1;
    tick(1);
    core_idle = 1'b1;
    tick(3);
    chk("standby", 0, flash_standby);
    sfr_read(ADDR_WR_CTRL, 8'h00);
    core_idle = 1'b0;
    tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {sys_clk, nrst, sfr_wr, sfr_rd, core_idle, core_stop, fetch_req} = '0;
    {opcode_exec, reti_exec, instr_done, sfr_addr, sfr_wdata, opcode} = '0;
    fetch_addr = 16'h0000;
    lock_bits = 8'hFF;
    tick(16);
    nrst = 1'b1;
    tick(1);
    t_regs();
    t_power();
    t_patch();
    t_trap();
    t_reti();
    t_cancel();
    t_write();
    t_locked(8'h0F, 8'h00);
    t_locked(8'h11, 8'h05);
    t_locked(8'h13, 8'h80);
    t_rst();
    end_sim();
  end

  // hang guard, well past the expected run of a few thousand cycles
  initial begin
    #1000000;
    failures++;
    end_sim();
  end
endmodule
